// [verilog/vcr_regs.sv]
// Purpose: Second-channel resource control, status and channel arbitration table.
// Assumes: AHB-Lite slave on hclk at 10 MHz; status inputs are synchronous to hclk.
// Notes: Settings are driven out to the arbiters; the table is flattened phase 0 first.
// What this block does
// - Each bit of the eight-bit class map stands for one traffic class mapped to this channel.
// - Bit zero of the class map always reads zero and writes to it are dropped.
// - The class map resets to zero and may then be replaced by an EEPROM load.
// - Writing one to the load bit applies the port arbitration table; it reads zero.
// - Only schemes 000b, 011b and 100b are kept; any other code becomes 000b, the reset.
// - The writable channel identifier resets to 001b with the strap set, else 000b.
// - The top control bit enables the channel when one and resets to zero.
// - The table status flag sets whenever any port arbitration entry is written.
// - The table status flag clears once the hardware finishes a requested table load.
// - Negotiation pending reads high while negotiating and resets to zero.
// - A writable and readable table holds 32 phases of four bits each.
// - Each phase keeps a three-bit channel identifier; its top bit is reserved.
// - Eight phases pack per word, phase n at nibble n mod 8 of word n div 8.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vcr_regs
  import vcr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic id_strap,
  input wire logic eeprom_map_valid,
  input wire logic [7:0] eeprom_map_data,
  input wire logic port_table_written,
  input wire logic table_load_done,
  input wire logic negotiation_busy,
  output logic [7:0] class_to_channel_map,
  output logic [2:0] port_arb_select,
  output logic [2:0] channel_identifier,
  output logic channel_enable,
  output logic port_table_load,
  output logic [127:0] channel_arb_table
);

  logic wr_pend;
  logic rd_load;
  logic [31:0] addr_q;
  logic [7:0] map_ff;
  logic [2:0] sel_ff;
  logic [2:0] id_ff;
  logic en_ff;
  logic load_ff;
  logic load_wait_ff;
  logic tstat_ff;
  logic neg_ff;
  logic strap_taken_ff;
  logic [31:0] rdata_ff;
  logic hresp_ff;
  logic [31:0] tbl_word [VCR_TBL_WORDS];

  vcr_ahb_front u_front (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .wr_pend(wr_pend),
    .rd_load(rd_load),
    .addr_q(addr_q)
  );

  // Address decode of the captured data-phase address.
  wire logic hit_ctrl = (addr_q == VCR_CTRL_ADDR);
  wire logic hit_stat = (addr_q == VCR_STAT_ADDR);
  wire logic hit_tbl = (addr_q[31:VCR_TBL_BLK_LSB] == VCR_TBL_ADDR[31:VCR_TBL_BLK_LSB]);
  wire logic [1:0] tbl_idx = addr_q[VCR_TBL_IDX_MSB:VCR_TBL_IDX_LSB];
  wire logic wr_ctrl = wr_pend & hit_ctrl;
  wire logic wr_tbl = wr_pend & hit_tbl;

  // Write data fields of the control register.
  wire logic [7:0] w_map = hwdata[VCR_MAP_MSB:VCR_MAP_LSB];
  wire logic [2:0] w_sel = hwdata[VCR_SEL_MSB:VCR_SEL_LSB];
  wire logic [2:0] w_id = hwdata[VCR_ID_MSB:VCR_ID_LSB];
  wire logic w_load = hwdata[VCR_LOAD_BIT];
  wire logic w_en = hwdata[VCR_EN_BIT];

  // Class map: a software write wins over an EEPROM load arriving together.
  wire logic [7:0] map_src = wr_ctrl ? w_map : eeprom_map_data;
  wire logic map_we = wr_ctrl | eeprom_map_valid;
  wire logic [7:0] nxt_map = {map_src[7:1], 1'b0};

  // Unsupported scheme codes collapse to the fixed default.
  wire logic sel_legal = (w_sel == VCR_ARB_FIXED) | (w_sel == VCR_ARB_WRR)
    | (w_sel == VCR_ARB_TIME_WRR);
  wire logic [2:0] nxt_sel = sel_legal ? w_sel : VCR_ARB_FIXED;

  wire logic [2:0] strap_id = id_strap ? VCR_ID_STRAP_ONE : VCR_ID_STRAP_ZERO;
  wire logic [2:0] nxt_id = wr_ctrl ? w_id : strap_id;
  wire logic id_we = wr_ctrl | ~strap_taken_ff;

  wire logic nxt_load = wr_ctrl & w_load;

  // Set wins: an entry written as a load finishes leaves the flag standing.
  wire logic tstat_clr = table_load_done & load_wait_ff;
  wire logic nxt_tstat = port_table_written | (tstat_ff & ~tstat_clr);
  wire logic nxt_load_wait = nxt_load | (load_wait_ff & ~table_load_done);

  // Read views; reserved positions and the load bit are constant zero.
  wire logic [31:0] ctrl_view = {en_ff, 4'h0, id_ff, 4'h0, sel_ff, 1'b0, 8'h00, map_ff};
  wire logic [31:0] stat_view = {14'h0000, neg_ff, tstat_ff, 16'h0000};
  wire logic [31:0] nxt_rdata = hit_ctrl ? ctrl_view
    : hit_stat ? stat_view
    : hit_tbl ? tbl_word[tbl_idx]
    : 32'h0000_0000;

  genvar gi;
  generate
    for (gi = 0; gi < VCR_TBL_WORDS; gi++)
    begin : g_tbl
      // Word gi holds phases 8*gi to 8*gi+7, lowest phase in the low nibble.
      vcr_table_word u_word (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(wr_tbl & (tbl_idx == 2'(gi))),
        .wdata(hwdata),
        .word_ff(tbl_word[gi])
      );
      assign channel_arb_table[32*gi +: 32] = tbl_word[gi];
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      map_ff <= VCR_MAP_RST;
      sel_ff <= VCR_ARB_FIXED;
      id_ff <= VCR_ID_STRAP_ZERO;
      en_ff <= VCR_EN_RST;
      strap_taken_ff <= 1'b0;
    end
    else
    begin
      if (map_we)
      begin
        map_ff <= nxt_map;
      end
      if (wr_ctrl)
      begin
        sel_ff <= nxt_sel;
        en_ff <= w_en;
      end
      if (id_we)
      begin
        id_ff <= nxt_id;
      end
      strap_taken_ff <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      load_ff <= 1'b0;
      load_wait_ff <= 1'b0;
      tstat_ff <= 1'b0;
      neg_ff <= 1'b0;
    end
    else
    begin
      load_ff <= nxt_load;
      load_wait_ff <= nxt_load_wait;
      tstat_ff <= nxt_tstat;
      neg_ff <= negotiation_busy;
    end
  end

  // Read data only changes when a read is being answered.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_ff <= 32'h0000_0000;
      hresp_ff <= VCR_HRESP_OKAY;
    end
    else
    begin
      if (rd_load)
      begin
        rdata_ff <= nxt_rdata;
      end
      hresp_ff <= VCR_HRESP_OKAY;
    end
  end

  assign hrdata = rdata_ff;
  assign hresp = hresp_ff;
  assign class_to_channel_map = map_ff;
  assign port_arb_select = sel_ff;
  assign channel_identifier = id_ff;
  assign channel_enable = en_ff;
  assign port_table_load = load_ff;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_read_taken;
    hsel && hready && htrans[VCR_HTRANS_ACTIVE_BIT] && !hwrite && (hsize == VCR_HSIZE_WORD);
  endsequence

  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  sequence s_ctrl_write;
    wr_ctrl;
  endsequence

  a_read_wait_state: assert property (s_read_taken |=> s_one_wait)
    else $error("read did not answer after exactly one wait state");

  a_map_bit0_zero: assert property (class_to_channel_map[0] == 1'b0)
    else $error("class map bit zero is not zero");

  a_map_write: assert property (s_ctrl_write |=>
    class_to_channel_map == {$past(hwdata[7:1]), 1'b0})
    else $error("class map did not take the written value");

  a_map_eeprom: assert property (eeprom_map_valid && !wr_ctrl |=>
    class_to_channel_map == {$past(eeprom_map_data[7:1]), 1'b0})
    else $error("class map did not take the EEPROM value");

  a_load_one_pulse: assert property (s_ctrl_write ##0 w_load |=>
    port_table_load ##1 !port_table_load)
    else $error("table load request was not a single pulse");

  a_load_reads_zero: assert property (rd_load && hit_ctrl |=> hrdata[VCR_LOAD_BIT] == 1'b0)
    else $error("load bit read back as one");

  a_sel_legal_code: assert property (port_arb_select inside {
    VCR_ARB_FIXED, VCR_ARB_WRR, VCR_ARB_TIME_WRR})
    else $error("arbitration select holds an unsupported code");

  a_sel_default: assert property (s_ctrl_write ##0 !sel_legal |=>
    port_arb_select == VCR_ARB_FIXED)
    else $error("unsupported scheme code was not replaced by the default");

  a_id_strap: assert property ($rose(strap_taken_ff) && !$past(wr_ctrl) |->
    channel_identifier == (id_strap ? VCR_ID_STRAP_ONE : VCR_ID_STRAP_ZERO))
    else $error("channel identifier did not follow the strap after reset");

  a_enable_write: assert property (s_ctrl_write |=>
    channel_enable == $past(hwdata[VCR_EN_BIT]))
    else $error("channel enable did not take the written bit");

  a_tstat_set: assert property (port_table_written |=> tstat_ff)
    else $error("table status flag not set after an entry write");

  // Here the done pulse comes two cycles after the load bit is written, one cycle after the load pulse.
  a_tstat_clear: assert property (s_ctrl_write ##0 w_load ##1
    (!port_table_written && !table_load_done) ##1 (table_load_done && !port_table_written)
    |=> !tstat_ff)
    else $error("table status flag not cleared after the load finished");

  // Read data is captured one cycle after the pending copy took the busy level.
  a_neg_follow: assert property (rd_load && hit_stat |=>
    hrdata[VCR_NEG_BIT] == $past(negotiation_busy, 2))
    else $error("negotiation pending did not report the channel state");

  a_tbl_reserved: assert property (
    (channel_arb_table[127:96] & ~VCR_TBL_ENTRY_MASK) == 32'h0
    && (channel_arb_table[31:0] & ~VCR_TBL_ENTRY_MASK) == 32'h0)
    else $error("reserved phase bit is set in the table");

  a_tbl_write_place: assert property (wr_tbl |=>
    tbl_word[$past(tbl_idx)] == ($past(hwdata) & VCR_TBL_ENTRY_MASK))
    else $error("table word did not take the written phases");

  a_stat_reserved: assert property (rd_load && hit_stat |=>
    hrdata[15:0] == 16'h0 && hrdata[31:18] == 14'h0)
    else $error("reserved status bits read nonzero");

endmodule
`default_nettype wire

// [verilog/vcr_pkg.sv]
// Purpose: Shared constants for the second-channel resource register bank.
// Assumes: AHB-Lite access with 32-bit words; one aligned word per register.
// Notes: Byte addresses are the printed configuration offsets.
package vcr_pkg;

  // Register byte addresses.
  localparam logic [31:0] VCR_CTRL_ADDR = 32'h0000_0160;
  localparam logic [31:0] VCR_STAT_ADDR = 32'h0000_0164;
  localparam logic [31:0] VCR_TBL_ADDR = 32'h0000_0170;

  // The table spans four words on a 16-byte aligned base.
  localparam int VCR_TBL_WORDS = 4;
  localparam int VCR_TBL_IDX_LSB = 2;
  localparam int VCR_TBL_IDX_MSB = 3;
  localparam int VCR_TBL_BLK_LSB = 4;
  localparam int VCR_PHASE_W = 4;
  localparam int VCR_PHASES_PER_WORD = 8;
  localparam logic [31:0] VCR_TBL_ENTRY_MASK = 32'h7777_7777;
  localparam logic [31:0] VCR_TBL_RST = 32'h0000_0000;

  // Control register fields.
  localparam int VCR_MAP_LSB = 0;
  localparam int VCR_MAP_MSB = 7;
  localparam int VCR_LOAD_BIT = 16;
  localparam int VCR_SEL_LSB = 17;
  localparam int VCR_SEL_MSB = 19;
  localparam int VCR_ID_LSB = 24;
  localparam int VCR_ID_MSB = 26;
  localparam int VCR_EN_BIT = 31;

  // Status register fields.
  localparam int VCR_TSTAT_BIT = 16;
  localparam int VCR_NEG_BIT = 17;

  // Reset values.
  localparam logic [7:0] VCR_MAP_RST = 8'h00;
  localparam logic [2:0] VCR_ID_STRAP_ONE = 3'h1;
  localparam logic [2:0] VCR_ID_STRAP_ZERO = 3'h0;
  localparam logic VCR_EN_RST = 1'b0;

  // Port arbitration schemes accepted by this channel.
  typedef enum logic [2:0] {
    VCR_ARB_FIXED = 3'b000,
    VCR_ARB_WRR = 3'b011,
    VCR_ARB_TIME_WRR = 3'b100
  } vcr_arb_sel_t;

  // AHB-Lite encodings.
  localparam int VCR_HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] VCR_HSIZE_WORD = 3'h2;
  localparam logic VCR_HRESP_OKAY = 1'b0;

endpackage

// [verilog/vcr_ahb_front.sv]
// Purpose: AHB-Lite address-phase capture with one wait state on reads.
// Assumes: Single whole-word transfers; hready is this slave's hreadyout.
// Notes: Writes complete with no wait; reads insert one so that data is fresh.
`timescale 1ns/1ps
`default_nettype none
module vcr_ahb_front
  import vcr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic wr_pend,
  output logic rd_load,
  output logic [31:0] addr_q
);

  wire logic take;
  wire logic take_wr;
  wire logic take_rd;

  // Sub-word transfers finish normally but touch nothing.
  assign take = hsel & hready & htrans[VCR_HTRANS_ACTIVE_BIT] & (hsize == VCR_HSIZE_WORD);
  assign take_wr = take & hwrite;
  assign take_rd = take & ~hwrite;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q <= 32'h0000_0000;
      wr_pend <= 1'b0;
      rd_load <= 1'b0;
      hreadyout <= 1'b1;
    end
    else
    begin
      if (take)
      begin
        addr_q <= haddr;
      end
      wr_pend <= take_wr;
      rd_load <= take_rd;
      hreadyout <= ~take_rd;
    end
  end

endmodule
`default_nettype wire

// [verilog/vcr_table_word.sv]
// Purpose: One word of eight channel arbitration phases.
// Assumes: The write strobe and data come from the same clock domain.
// Notes: The top bit of every four-bit phase is held at zero.
`timescale 1ns/1ps
`default_nettype none
module vcr_table_word
  import vcr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [31:0] wdata,
  output logic [31:0] word_ff
);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      word_ff <= VCR_TBL_RST;
    end
    else if (we)
    begin
      word_ff <= wdata & VCR_TBL_ENTRY_MASK;
    end
  end

endmodule
`default_nettype wire

// [sim/vcr_regs_tb_top.sv]
// Purpose: Self-checking bench for the second-channel resource register bank.
// Assumes: hready is looped back from hreadyout; side inputs change on rising edges.
// Notes: Expected values are worked out here from the field layout, never read back first.
`timescale 1ns/1ps
`default_nettype none
module vcr_regs_tb_top;
  import vcr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, id_strap, negotiation_busy, hreadyout, hresp;
  logic channel_enable, port_table_load;
  logic [31:0] haddr, hwdata, hrdata, rd, exp_w, loads;
  logic [31:0] tw [4];
  logic [1:0] htrans;
  logic [2:0] hsize, port_arb_select, channel_identifier, strb;
  logic [7:0] eeprom_map_data, class_to_channel_map;
  logic [127:0] channel_arb_table;
  wire logic hready;
  int n_errors, checks_done, cycles;

  assign hready = hreadyout;

  vcr_regs vcr_regs_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .id_strap(id_strap),
    .eeprom_map_valid(strb[2]), .eeprom_map_data(eeprom_map_data),
    .port_table_written(strb[0]), .table_load_done(strb[1]),
    .negotiation_busy(negotiation_busy), .class_to_channel_map(class_to_channel_map),
    .port_arb_select(port_arb_select), .channel_identifier(channel_identifier),
    .channel_enable(channel_enable), .port_table_load(port_table_load),
    .channel_arb_table(channel_arb_table)
  );

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Counting load pulses cycle by cycle also catches a pulse that lasts too long.
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (port_table_load === 1'b1)
      loads <= loads + 32'h1;
    if (cycles == 6000)
    begin
      n_errors = n_errors + 1;
      summarize();
    end
  end

  task automatic summarize;
    $display("Checks done %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Entered at a rising edge and left at the edge that takes the data phase.
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wdata;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr32(input logic [31:0] addr, input logic [31:0] data);
    xfer(1'b1, addr, data, VCR_HSIZE_WORD);
  endtask

  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp, input string what);
    xfer(1'b0, addr, 32'h0, VCR_HSIZE_WORD);
    check(rd, exp, what);
  endtask

  task automatic pulse(input logic [2:0] m);
    @(posedge hclk);
    strb <= m;
    @(posedge hclk);
    strb <= 3'h0;
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = VCR_HSIZE_WORD;
    hwdata = 32'h0;
    id_strap = 1'b1;
    strb = 3'h0;
    eeprom_map_data = 8'h00;
    negotiation_busy = 1'b0;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    loads = 32'h0;
    do_reset();
    rd_chk(VCR_CTRL_ADDR, 32'h0100_0000, "ctrl after reset");
    rd_chk(VCR_STAT_ADDR, 32'h0, "status after reset");
    for (int k = 0; k < 4; k++)
      rd_chk(VCR_TBL_ADDR + 32'(4 * k), 32'h0, "table after reset");
    wr32(VCR_CTRL_ADDR, 32'hffff_ffff);
    rd_chk(VCR_CTRL_ADDR, 32'h8700_00fe, "ctrl all ones");
    check({31'h0, channel_enable}, 32'h1, "enable out");
    check(loads, 32'h1, "load pulse count");
    // Finish the load that the all-ones write requested, so that later done pulses are stray.
    pulse(3'h2);
    wr32(VCR_CTRL_ADDR, 32'h0);
    rd_chk(VCR_CTRL_ADDR, 32'h0, "ctrl cleared");
    check(loads, 32'h1, "no load without bit");
    // Every select code, legal or not, in turn.
    for (int c = 0; c < 8; c++)
    begin
      exp_w = (c == 0 || c == 3 || c == 4) ? 32'(c) << 17 : 32'h0;
      wr32(VCR_CTRL_ADDR, 32'(c) << 17);
      rd_chk(VCR_CTRL_ADDR, exp_w, "select code");
      check({29'h0, port_arb_select}, {29'h0, exp_w[19:17]}, "select out");
    end
    // Walk one map bit at a time, with the identifier following the bit index.
    for (int k = 0; k < 8; k++)
    begin
      exp_w = (32'h1 << k) | (32'(k) << 24);
      wr32(VCR_CTRL_ADDR, exp_w);
      exp_w[0] = 1'b0;
      rd_chk(VCR_CTRL_ADDR, exp_w, "map bit");
      check({24'h0, class_to_channel_map}, {24'h0, exp_w[7:0]}, "map out");
      check({29'h0, channel_identifier}, 32'(k), "id out");
    end
    eeprom_map_data <= 8'ha5;
    pulse(3'h4);
    rd_chk(VCR_CTRL_ADDR, 32'h0700_00a4, "eeprom map");
    for (int k = 0; k < 4; k++)
    begin
      tw[k] = 32'hfedc_ba98 + 32'h1234_5678 * 32'(k);
      wr32(VCR_TBL_ADDR + 32'(4 * k), tw[k]);
      rd_chk(VCR_TBL_ADDR + 32'(4 * k), tw[k] & 32'h7777_7777, "table word");
    end
    for (int n = 0; n < 32; n++)
      check({28'h0, channel_arb_table[4 * n +: 4]},
            {28'h0, tw[n / 8][4 * (n % 8) +: 4] & 4'h7}, "phase");
    wr32(VCR_STAT_ADDR, 32'hffff_ffff);
    rd_chk(VCR_STAT_ADDR, 32'h0, "status read only");
    wr32(32'h0000_0168, 32'hffff_ffff);
    // A byte-sized write completes but must leave the control word alone.
    xfer(1'b1, VCR_CTRL_ADDR, 32'hffff_ffff, 3'h0);
    rd_chk(32'h0000_0168, 32'h0, "unmapped");
    rd_chk(VCR_CTRL_ADDR, 32'h0700_00a4, "ctrl untouched");
    check({31'h0, hresp}, 32'h0, "response okay");
    pulse(3'h1);
    rd_chk(VCR_STAT_ADDR, 32'h0001_0000, "table status set");
    // A completion that was never requested must leave the flag alone.
    pulse(3'h2);
    rd_chk(VCR_STAT_ADDR, 32'h0001_0000, "stray done");
    wr32(VCR_CTRL_ADDR, 32'h0001_0000);
    pulse(3'h2);
    rd_chk(VCR_STAT_ADDR, 32'h0, "table status cleared");
    check(loads, 32'h2, "second load pulse");
    negotiation_busy <= 1'b1;
    rd_chk(VCR_STAT_ADDR, 32'h0002_0000, "negotiating");
    negotiation_busy <= 1'b0;
    rd_chk(VCR_STAT_ADDR, 32'h0, "negotiation done");
    id_strap <= 1'b0;
    do_reset();
    rd_chk(VCR_CTRL_ADDR, 32'h0, "ctrl reset strap low");
    rd_chk(VCR_TBL_ADDR + 32'hc, 32'h0, "table reset again");
    summarize();
  end
endmodule
`default_nettype wire
